// ---- flag_reg.sv ----
// one sticky flag: set beats clear, reset loads rst_val
module flag_reg
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic rst_val,
    // control
    input  wire logic set,
    input  wire logic clr,
    // state
    output logic      flag
);
    // a set in the same cycle as a clear is kept
    always_ff @(posedge clk)
    begin
        if (rst)
            flag <= rst_val;
        else if (set)
            flag <= 1'b1;
        else if (clr)
            flag <= 1'b0;
    end
endmodule : flag_reg

// ---- irq_flags_pkg.sv ----
package irq_flags_pkg;

    // register offsets
    localparam logic [7:0] OFS_FLAGS_PRI     = 8'h00;
    localparam logic [7:0] OFS_FLAGS_SEC     = 8'h01;
    localparam logic [7:0] OFS_MASK_PRI      = 8'h02;
    localparam logic [7:0] OFS_MASK_SEC      = 8'h03;
    localparam logic [7:0] OFS_WR_INDEX      = 8'h04;
    localparam logic [7:0] OFS_LOST_COUNT    = 8'h05;
    localparam logic [7:0] OFS_RD_INDEX      = 8'h06;
    localparam logic [7:0] OFS_STORE_PORT    = 8'h07;
    localparam logic [7:0] OFS_STORE_CFG     = 8'h08;
    localparam logic [7:0] OFS_MODE_CFG      = 8'h09;
    localparam logic [7:0] OFS_OXI_CFG       = 8'h0a;
    localparam logic [7:0] OFS_EMIT1         = 8'h0c;
    localparam logic [7:0] OFS_EMIT2         = 8'h0d;
    localparam logic [7:0] OFS_EMIT_PROX     = 8'h10;
    localparam logic [7:0] OFS_SLOT_LO       = 8'h11;
    localparam logic [7:0] OFS_SLOT_HI       = 8'h12;
    localparam logic [7:0] OFS_TEMP_WHOLE    = 8'h1f;
    localparam logic [7:0] OFS_TEMP_FRAC     = 8'h20;
    localparam logic [7:0] OFS_TEMP_CFG      = 8'h21;
    localparam logic [7:0] OFS_PROX_THRESH   = 8'h30;
    localparam logic [7:0] OFS_REVISION      = 8'hfe;
    localparam logic [7:0] OFS_IDENT         = 8'hff;

    // field positions
    localparam int BIT_ALMOST_FULL  = 7;
    localparam int BIT_NEW_SAMPLE   = 6;
    localparam int BIT_AMB_OVF      = 5;
    localparam int BIT_PROX_HIT     = 4;
    localparam int BIT_SUPPLY_GOOD  = 0;
    localparam int BIT_TEMP_READY   = 1;

    // values after reset and fixed constants
    localparam logic [7:0] RST_REG          = 8'h00;
    localparam logic [7:0] RST_FLAGS_PRI    = 8'h01; // supply rise at reset counts as power ready
    localparam logic [7:0] REVISION_VALUE   = 8'h01; // arbitrary value
    localparam logic [7:0] IDENT_VALUE      = 8'h5a; // arbitrary value
    localparam logic [5:0] STORE_DEPTH      = 6'h20;

    // measurement modes
    localparam logic [2:0] MODE_HEART       = 3'h2;
    localparam logic [2:0] MODE_OXI         = 3'h3;
    localparam logic [2:0] MODE_MULTI       = 3'h7;

    // register access from the serial front end
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // events from the measurement datapaths
    typedef struct packed {
        logic       sample_push;
        logic       amb_limit;
        logic       prox_reading;
        logic [7:0] ir_count_hi;
        logic       supply_above_lockout;
        logic       temp_done;
    } sensor_evt_t;

endpackage : irq_flags_pkg

// ---- sensor_host_model.sv ----
// host processor side: register strobes plus the board pull-up on the interrupt line
module sensor_host_model
(
    // clock
    input  wire logic                    clk,
    // register access toward the device
    output irq_flags_pkg::reg_req_t      req,
    input  wire logic [7:0]              rdata,
    // interrupt pin, open drain
    input  wire logic                    irq_pin_out,
    input  wire logic                    irq_pin_oe,
    output logic                         irq_level
);
    timeunit 1ns;
    timeprecision 1ps;
    import irq_flags_pkg::*;

    // released line floats up to the pull-up, so an idle pin never reads as a stale low
    assign irq_level = irq_pin_oe ? irq_pin_out : 1'b1;

    initial req = '0;

    // one-cycle write strobe launched just after a rising edge
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        req.rd    <= 1'b0;
        req.wr    <= 1'b1;
        req.addr  <= addr;
        req.wdata <= data;
        @(posedge clk);
        req.wr    <= 1'b0;
        @(negedge clk);
    endtask : write_reg

    // read data lands on the edge that takes the strobe; pick it up half a cycle later
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        req.wr   <= 1'b0;
        req.rd   <= 1'b1;
        req.addr <= addr;
        @(posedge clk);
        req.rd   <= 1'b0;
        @(negedge clk);
        data = rdata;
    endtask : read_reg

endmodule : sensor_host_model

// ---- sensor_interrupt_flags_regmap.sv ----
module sensor_interrupt_flags_regmap
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // register access
    input  wire irq_flags_pkg::reg_req_t    req,
    output logic [7:0]                      rdata,
    // store port byte supplied by the sample store, then the temperature readings
    input  wire logic [7:0]                 store_byte,
    input  wire logic [7:0]                 temp_whole_in,
    input  wire logic [3:0]                 temp_frac_in,
    // datapath events
    input  wire irq_flags_pkg::sensor_evt_t evt,
    // interrupt pin, open drain
    input  wire logic                       irq_pin_in,
    output logic                            irq_pin_out,
    output logic                            irq_pin_oe,
    // configuration to other units
    output logic [2:0]                      mode,
    output logic [7:0]                      wr_index,
    output logic [7:0]                      rd_index
);
    import irq_flags_pkg::*;

    typedef enum logic [1:0] {
        PH_PROXIMITY = 2'b01,
        PH_MEASURE   = 2'b10
    } phase_t;

    logic [7:0] mask_pri_reg;
    logic [7:0] mask_sec_reg;
    logic [7:0] wr_index_reg;
    logic [7:0] lost_reg;
    logic [7:0] rd_index_reg;
    logic [7:0] store_cfg_reg;
    logic [7:0] mode_cfg_reg;
    logic [7:0] oxi_cfg_reg;
    logic [7:0] emit1_reg;
    logic [7:0] emit2_reg;
    logic [7:0] emit_prox_reg;
    logic [7:0] slot_lo_reg;
    logic [7:0] slot_hi_reg;
    logic [7:0] prox_thresh_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       supply_d_reg;
    logic [2:0] sync_reg;
    phase_t     phase_reg;
    phase_t     phase_next;

    // pin readback only feeds the echo check; a line stuck high on the board shows up there
    always_ff @(posedge clk)
    begin
        if (rst)
            sync_reg <= 3'h0;
        else
            sync_reg <= {sync_reg[1:0], irq_pin_in};
    end
    wire pin_low_seen = !sync_reg[2] && !sync_reg[1];

    // decode of register strobes
    function automatic logic hit(input reg_req_t r, input logic [7:0] a);
        return r.addr == a;
    endfunction : hit

    wire rd_pri   = req.rd && hit(req, OFS_FLAGS_PRI);
    wire rd_sec   = req.rd && hit(req, OFS_FLAGS_SEC);
    wire rd_port  = req.rd && hit(req, OFS_STORE_PORT);
    wire rd_frac  = req.rd && hit(req, OFS_TEMP_FRAC);
    wire wr_mode  = req.wr && hit(req, OFS_MODE_CFG);
    wire measure_mode = (mode_cfg_reg[2:0] == MODE_HEART) || (mode_cfg_reg[2:0] == MODE_OXI)
                        || (mode_cfg_reg[2:0] == MODE_MULTI);

    // free slots: depth minus the occupancy between the indices
    wire [4:0] used_slots = 5'(wr_index_reg[4:0] - rd_index_reg[4:0]);
    wire [5:0] free_slots = 6'(STORE_DEPTH - {1'b0, used_slots});
    wire       almost_full_hit = measure_mode && evt.sample_push
                                 && (free_slots == {2'h0, store_cfg_reg[3:0]} + 6'h1);

    // proximity phase: a mode write re-arms it while the proximity mask is on
    wire prox_reach = (phase_reg == PH_PROXIMITY) && measure_mode && evt.prox_reading
                      && (evt.ir_count_hi >= prox_thresh_reg);
    always_comb
    begin
        phase_next = phase_reg;
        unique case (phase_reg)
            PH_PROXIMITY: if (prox_reach) phase_next = PH_MEASURE;
            PH_MEASURE:   phase_next = PH_MEASURE;
        endcase
        // any mode write restarts the phase, even when the value is unchanged
        if (wr_mode)
            phase_next = mask_pri_reg[BIT_PROX_HIT] ? PH_PROXIMITY : PH_MEASURE;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            phase_reg <= PH_MEASURE;
        else
            phase_reg <= phase_next;
    end

    // supply rising edge detector
    always_ff @(posedge clk)
    begin
        if (rst)
            supply_d_reg <= 1'b1;
        else
            supply_d_reg <= evt.supply_above_lockout;
    end
    wire supply_rise = evt.supply_above_lockout && !supply_d_reg;

    // sticky flags; reading the primary register zeroes all its bits
    logic f_full, f_new, f_amb, f_prox, f_pwr, f_temp;
    flag_reg u_full (.clk(clk), .rst(rst), .rst_val(1'b0), .set(almost_full_hit),
                     .clr(rd_pri), .flag(f_full));
    flag_reg u_new  (.clk(clk), .rst(rst), .rst_val(1'b0), .set(measure_mode && evt.sample_push),
                     .clr(rd_pri || rd_port), .flag(f_new));
    flag_reg u_amb  (.clk(clk), .rst(rst), .rst_val(1'b0), .set(evt.amb_limit),
                     .clr(rd_pri), .flag(f_amb));
    flag_reg u_prox (.clk(clk), .rst(rst), .rst_val(1'b0), .set(prox_reach),
                     .clr(rd_pri), .flag(f_prox));
    flag_reg u_pwr  (.clk(clk), .rst(rst), .rst_val(RST_FLAGS_PRI[BIT_SUPPLY_GOOD]), .set(supply_rise),
                     .clr(rd_pri), .flag(f_pwr));
    flag_reg u_temp (.clk(clk), .rst(rst), .rst_val(1'b0), .set(evt.temp_done),
                     .clr(rd_sec || rd_frac), .flag(f_temp));

    wire [7:0] flags_pri = {f_full, f_new, f_amb, f_prox, 3'h0, f_pwr};
    wire [7:0] flags_sec = {6'h0, f_temp, 1'b0};

    // pin low while an enabled flag or power-ready is pending
    wire irq_active = |(flags_pri & mask_pri_reg) || f_pwr
                      || (f_temp && mask_sec_reg[BIT_TEMP_READY]);
    assign irq_pin_out = 1'b0;
    assign irq_pin_oe  = irq_active;

    // writable registers; masks reset disabled, unused mask bits held zero
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mask_pri_reg    <= RST_REG;
            mask_sec_reg    <= RST_REG;
            store_cfg_reg   <= RST_REG;
            mode_cfg_reg    <= RST_REG;
            oxi_cfg_reg     <= RST_REG;
            emit1_reg       <= RST_REG;
            emit2_reg       <= RST_REG;
            emit_prox_reg   <= RST_REG;
            slot_lo_reg     <= RST_REG;
            slot_hi_reg     <= RST_REG;
            prox_thresh_reg <= RST_REG;
        end
        else if (req.wr)
        begin
            if (hit(req, OFS_MASK_PRI))    mask_pri_reg    <= {req.wdata[7:4], 4'h0};
            if (hit(req, OFS_MASK_SEC))    mask_sec_reg    <= {6'h0, req.wdata[1], 1'b0};
            if (hit(req, OFS_STORE_CFG))   store_cfg_reg   <= req.wdata;
            if (wr_mode)                   mode_cfg_reg    <= req.wdata;
            if (hit(req, OFS_OXI_CFG))     oxi_cfg_reg     <= {1'b0, req.wdata[6:0]};
            if (hit(req, OFS_EMIT1))       emit1_reg       <= req.wdata;
            if (hit(req, OFS_EMIT2))       emit2_reg       <= req.wdata;
            if (hit(req, OFS_EMIT_PROX))   emit_prox_reg   <= req.wdata;
            if (hit(req, OFS_SLOT_LO))     slot_lo_reg     <= req.wdata;
            if (hit(req, OFS_SLOT_HI))     slot_hi_reg     <= req.wdata;
            if (hit(req, OFS_PROX_THRESH)) prox_thresh_reg <= req.wdata;
        end
    end

    // store indices: host writes win, pushes advance the write index, read index moves only on host writes, lost count saturates at 0xf
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_index_reg <= RST_REG;
            rd_index_reg <= RST_REG;
            lost_reg     <= RST_REG;
        end
        else
        begin
            if (req.wr && hit(req, OFS_WR_INDEX))
                wr_index_reg <= {3'h0, req.wdata[4:0]};
            else if (evt.sample_push && used_slots != 5'h1f)
                wr_index_reg <= {3'h0, 5'(wr_index_reg[4:0] + 5'h1)};
            if (req.wr && hit(req, OFS_RD_INDEX))
                rd_index_reg <= {3'h0, req.wdata[4:0]};
            if (req.wr && hit(req, OFS_LOST_COUNT))
                lost_reg <= {3'h0, req.wdata[4:0]};
            else if (evt.sample_push && used_slots == 5'h1f && lost_reg != 8'h0f)
                lost_reg <= 8'(lost_reg + 8'h01);
        end
    end

    // read mux
    always_comb
    begin
        unique case (req.addr)
            OFS_FLAGS_PRI:   rdata_next = flags_pri;
            OFS_FLAGS_SEC:   rdata_next = flags_sec;
            OFS_MASK_PRI:    rdata_next = mask_pri_reg;
            OFS_MASK_SEC:    rdata_next = mask_sec_reg;
            OFS_WR_INDEX:    rdata_next = wr_index_reg;
            OFS_LOST_COUNT:  rdata_next = lost_reg;
            OFS_RD_INDEX:    rdata_next = rd_index_reg;
            OFS_STORE_PORT:  rdata_next = store_byte;
            OFS_STORE_CFG:   rdata_next = store_cfg_reg;
            OFS_MODE_CFG:    rdata_next = mode_cfg_reg;
            OFS_OXI_CFG:     rdata_next = oxi_cfg_reg;
            OFS_EMIT1:       rdata_next = emit1_reg;
            OFS_EMIT2:       rdata_next = emit2_reg;
            OFS_EMIT_PROX:   rdata_next = emit_prox_reg;
            OFS_SLOT_LO:     rdata_next = slot_lo_reg;
            OFS_SLOT_HI:     rdata_next = slot_hi_reg;
            OFS_TEMP_WHOLE:  rdata_next = temp_whole_in;
            OFS_TEMP_FRAC:   rdata_next = {4'h0, temp_frac_in};
            OFS_PROX_THRESH: rdata_next = prox_thresh_reg;
            OFS_REVISION:    rdata_next = REVISION_VALUE;
            OFS_IDENT:       rdata_next = IDENT_VALUE;
            default:         rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            rdata_reg <= RST_REG;
        else if (req.rd)
            rdata_reg <= rdata_next;
    end

    assign rdata    = rdata_reg;
    assign mode     = mode_cfg_reg[2:0];
    assign wr_index = wr_index_reg;
    assign rd_index = rd_index_reg;

    // checks
    property p_pin_on_pwr;
        @(posedge clk) disable iff (rst) f_pwr |-> irq_pin_oe;
    endproperty
    a_pin_on_pwr: assert property (p_pin_on_pwr) else $error("pin not low with power ready");

    property p_pri_clear;
        @(posedge clk) disable iff (rst)
        (rd_pri && !almost_full_hit && !evt.amb_limit && !prox_reach && !supply_rise
         && !(measure_mode && evt.sample_push)) |=> (flags_pri == 8'h00);
    endproperty
    a_pri_clear: assert property (p_pri_clear) else $error("primary flags not zeroed");

    property p_temp_set;
        @(posedge clk) disable iff (rst) evt.temp_done |=> f_temp;
    endproperty
    a_temp_set: assert property (p_temp_set) else $error("temp flag not set");

    property p_temp_clr;
        @(posedge clk) disable iff (rst) (rd_frac && !evt.temp_done) |=> !f_temp;
    endproperty
    a_temp_clr: assert property (p_temp_clr) else $error("temp flag not cleared");

    property p_new_port;
        @(posedge clk) disable iff (rst) (rd_port && !evt.sample_push) |=> !f_new;
    endproperty
    a_new_port: assert property (p_new_port) else $error("sample flag not cleared");

    property p_amb_set;
        @(posedge clk) disable iff (rst) evt.amb_limit |=> f_amb;
    endproperty
    a_amb_set: assert property (p_amb_set) else $error("ambient flag not set");

    property p_pwr_rise;
        @(posedge clk) disable iff (rst) $rose(evt.supply_above_lockout) |=> f_pwr;
    endproperty
    a_pwr_rise: assert property (p_pwr_rise) else $error("power flag missed");

    property p_pin_hold;
        @(posedge clk) disable iff (rst) (irq_pin_oe && !rd_pri && !rd_sec && !rd_port && !rd_frac
                                          && !req.wr) |=> irq_pin_oe;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin released early");

    property p_ident;
        @(posedge clk) disable iff (rst) (req.rd && hit(req, OFS_IDENT)) |=> rdata == IDENT_VALUE;
    endproperty
    a_ident: assert property (p_ident) else $error("identifier wrong");

    // a pin held low for three cycles must reach the end of the readback filter
    property p_pin_echo;
        @(posedge clk) disable iff (rst) irq_pin_oe [*3] |=> pin_low_seen;
    endproperty
    a_pin_echo: assert property (p_pin_echo) else $error("pin readback not low");
endmodule : sensor_interrupt_flags_regmap

// ---- sensor_interrupt_flags_regmap_bench.sv ----
module sensor_interrupt_flags_regmap_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_flags_pkg::*;

    logic        clk;
    logic        rst;
    reg_req_t    req;
    logic [7:0]  rdata;
    logic [7:0]  store_byte;
    logic [7:0]  temp_whole_in;
    logic [3:0]  temp_frac_in;
    sensor_evt_t evt;
    logic        irq_level;
    logic        irq_pin_out;
    logic        irq_pin_oe;
    logic [2:0]  mode;
    logic [7:0]  wr_index;
    logic [7:0]  rd_index;
    int          errors;
    int          compares;

    sensor_interrupt_flags_regmap dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
        .store_byte(store_byte), .temp_whole_in(temp_whole_in), .temp_frac_in(temp_frac_in),
        .evt(evt), .irq_pin_in(irq_level), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
        .mode(mode), .wr_index(wr_index), .rd_index(rd_index));

    sensor_host_model host (.clk(clk), .req(req), .rdata(rdata), .irq_pin_out(irq_pin_out),
        .irq_pin_oe(irq_pin_oe), .irq_level(irq_level));

    // free-running 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic report_and_stop();
        if (errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] v;
        host.read_reg(addr, v);
        check($sformatf("reg %h", addr), v, exp);
    endtask : expect_reg

    // pin is active low: 0 means an interrupt is pending
    task automatic expect_pin(input logic exp);
        check("interrupt pin", {7'h00, irq_level}, {7'h00, exp});
    endtask : expect_pin

    // one-cycle event pulse; ir count rides along for the proximity source
    task automatic pulse(input int which, input logic [7:0] ir = 8'h00);
        @(posedge clk);
        evt.ir_count_hi <= ir;
        case (which)
            0: evt.sample_push  <= 1'b1;
            1: evt.amb_limit    <= 1'b1;
            2: evt.prox_reading <= 1'b1;
            default: evt.temp_done <= 1'b1;
        endcase
        @(posedge clk);
        evt.sample_push  <= 1'b0;
        evt.amb_limit    <= 1'b0;
        evt.prox_reading <= 1'b0;
        evt.temp_done    <= 1'b0;
        @(negedge clk);
    endtask : pulse

    task automatic s_reset_and_map();
        expect_pin(1'b0);
        expect_reg(OFS_FLAGS_PRI, 8'h01);
        expect_pin(1'b1);
        expect_reg(OFS_FLAGS_PRI, 8'h00);
        expect_reg(OFS_MASK_PRI, 8'h00);
        expect_reg(OFS_MASK_SEC, 8'h00);
        host.write_reg(OFS_REVISION, 8'h77);
        host.write_reg(OFS_IDENT, 8'h77);
        host.write_reg(OFS_FLAGS_PRI, 8'hff);
        expect_pin(1'b1);
        expect_reg(OFS_REVISION, REVISION_VALUE);
        expect_reg(OFS_IDENT, IDENT_VALUE);
        expect_reg(OFS_FLAGS_PRI, 8'h00);
        expect_reg(8'h40, 8'h00);
        host.write_reg(OFS_RD_INDEX, 8'hff);
        check("read index", rd_index, 8'h1f);
        host.write_reg(OFS_MASK_PRI, 8'hf0);
        expect_reg(OFS_MASK_PRI, 8'hf0);
    endtask : s_reset_and_map

    task automatic s_almost_full();
        host.write_reg(OFS_MASK_PRI, 8'h80);
        host.write_reg(OFS_WR_INDEX, 8'h00);
        host.write_reg(OFS_RD_INDEX, 8'h00);
        host.write_reg(OFS_STORE_CFG, 8'h04);
        host.write_reg(OFS_MODE_CFG, {5'h00, MODE_OXI});
        check("mode", {5'h00, mode}, {5'h00, MODE_OXI});
        repeat (27) pulse(0);
        expect_pin(1'b1);
        pulse(0);
        expect_pin(1'b0);
        check("write index", wr_index, 8'h1c);
        expect_reg(OFS_FLAGS_PRI, 8'hc0);
        expect_pin(1'b1);
        host.write_reg(OFS_WR_INDEX, 8'h00);
        host.write_reg(OFS_RD_INDEX, 8'h00);
    endtask : s_almost_full

    task automatic s_sample_port();
        host.write_reg(OFS_MASK_PRI, 8'h00);
        pulse(0);
        expect_pin(1'b1);
        expect_reg(OFS_STORE_PORT, 8'ha5);
        expect_reg(OFS_FLAGS_PRI, 8'h00);
        host.write_reg(OFS_MASK_PRI, 8'h40);
        pulse(0);
        expect_pin(1'b0);
        expect_reg(OFS_STORE_PORT, 8'ha5);
        expect_pin(1'b1);
    endtask : s_sample_port

    task automatic s_ambient();
        host.write_reg(OFS_MASK_PRI, 8'h00);
        pulse(1);
        expect_pin(1'b1);
        expect_reg(OFS_FLAGS_PRI, 8'h20);
        host.write_reg(OFS_MASK_PRI, 8'h20);
        pulse(1);
        expect_pin(1'b0);
        expect_reg(OFS_FLAGS_PRI, 8'h20);
        expect_pin(1'b1);
        host.write_reg(OFS_MASK_PRI, 8'h00);
    endtask : s_ambient

    task automatic s_temperature();
        host.write_reg(OFS_MASK_SEC, 8'h02);
        pulse(3);
        expect_pin(1'b0);
        expect_reg(OFS_TEMP_FRAC, 8'h09);
        expect_pin(1'b1);
        expect_reg(OFS_FLAGS_SEC, 8'h00);
        pulse(3);
        expect_reg(OFS_FLAGS_SEC, 8'h02);
        expect_pin(1'b1);
        expect_reg(OFS_FLAGS_SEC, 8'h00);
        expect_reg(OFS_TEMP_WHOLE, 8'h19);
        host.write_reg(OFS_MASK_SEC, 8'h00);
    endtask : s_temperature

    task automatic s_supply();
        @(posedge clk);
        evt.supply_above_lockout <= 1'b0;
        repeat (3) @(posedge clk);
        evt.supply_above_lockout <= 1'b1;
        repeat (2) @(negedge clk);
        expect_pin(1'b0);
        expect_reg(OFS_FLAGS_PRI, 8'h01);
        expect_pin(1'b1);
    endtask : s_supply

    task automatic s_proximity();
        host.write_reg(OFS_MASK_PRI, 8'h10);
        host.write_reg(OFS_PROX_THRESH, 8'h40);
        host.write_reg(OFS_MODE_CFG, {5'h00, MODE_HEART});
        pulse(2, 8'h3f);
        expect_pin(1'b1);
        pulse(2, 8'h40);
        expect_pin(1'b0);
        // hold the pin low long enough for the readback filter to see it
        repeat (4) @(negedge clk);
        expect_reg(OFS_FLAGS_PRI, 8'h10);
        expect_pin(1'b1);
    endtask : s_proximity

    // watchdog: the whole sequence needs well under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    initial
    begin
        errors        = 0;
        compares      = 0;
        rst           = 1'b1;
        store_byte    = 8'ha5;
        temp_whole_in = 8'h19;
        temp_frac_in  = 4'h9;
        evt           = '0;
        evt.supply_above_lockout = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        s_reset_and_map();
        s_almost_full();
        s_sample_port();
        s_ambient();
        s_temperature();
        s_supply();
        s_proximity();
        report_and_stop();
    end

endmodule : sensor_interrupt_flags_regmap_bench
